// ===== core/ufs_defs.svh
`ifndef UFS_DEFS_SVH
`define UFS_DEFS_SVH
// register offsets (byte addresses)
`define UFS_OFS_GUARD 8'h00
`define UFS_OFS_MISC 8'h04
`define UFS_OFS_STAT 8'h08
`define UFS_OFS_EPCFG 8'h0C
`define UFS_OFS_FSEL 8'h10
`define UFS_OFS_FDATA 8'h14
// guard key that lifts write protection
`define UFS_GUARD_KEY 16'h0096
// misc control field positions
`define UFS_MISC_PLL 0
`define UFS_MISC_LREG 1
`define UFS_MISC_HREG 2
`define UFS_MISC_RST 3
`define UFS_MISC_VDET 4
`define UFS_MISC_WAIT 5
`define UFS_MISC_PULL 6
// status field positions
`define UFS_ST_REGOK 0
`define UFS_ST_PLLOK 1
`define UFS_ST_VBUS 2
`define UFS_ST_SUSP 3
`define UFS_ST_BRST 4
`define UFS_ST_RSM 5
`define UFS_ST_OPEN 6
// reset values
`define UFS_MISC_RESET 7'h00
`define UFS_EPCFG_RESET 8'h00
// endpoint layout: four 64-byte regions
`define UFS_EP_BYTES 64
`define UFS_FIFO_BYTES 256
// transfer type encoding rejected by the endpoints
`define UFS_TT_ISO 2'h1
// timing
`define UFS_CLK_MHZ 25
`define UFS_REG_STAB_US 1000
`define UFS_PLL_STAB_US 1000
`define UFS_RST_SE0_NS 2500
`define UFS_SUSP_IDLE_US 3000
`define UFS_RST_CYC ((`UFS_RST_SE0_NS * `UFS_CLK_MHZ + 999) / 1000)
`endif

// ===== core/ufs_pkg.sv
package ufs_pkg;
  // misc control register image
  typedef struct packed {
    logic pull_en;
    logic wait_sel;
    logic vdet;
    logic rst_rel;
    logic hreg;
    logic lreg;
    logic pll;
  } ufs_misc_t;
  // general endpoint configuration
  typedef struct packed {
    logic en;
    logic [1:0] ttype;
    logic [3:0] num;
    logic dir;
  } ufs_epcfg_t;
  // software register port
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ufs_req_t;
  typedef enum logic [1:0] {UFS_SE0, UFS_J, UFS_K, UFS_SE1} ufs_line_t;
  typedef enum logic [1:0] {UFS_S_RUN, UFS_S_SUSP, UFS_S_RESET} ufs_sie_t;
endpackage

// ===== core/ufs_ctrl.sv
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ufs_defs.svh"
// Functional notes
// - device-only target; full-speed line decoding, 12 Mbps, D+ pulled up
// - control, bulk, interrupt endpoints; isochronous type is refused
// - endpoint 0 plus three endpoints with direction, number, enable
// - 256-byte FIFO, one fixed 64-byte region per endpoint
// - 48 MHz from 12 MHz times four; host supplies stable oscillator
// - software bit runs the PLL; clock unusable until stabilization passes
// - serial engine tracks suspend, resume and bus reset events
// - D+ pull-up is software enabled and disabled
// - two regulator enables; outputs unusable until stabilization time passes
// - regulator controls and FIFO locked while bus power absent
// - writing one to reset release lets the USB logic run
// - detect bit connects logic; only then USB registers are accessible
module ufs_ctrl import ufs_pkg::*; #(
  parameter int REG_STAB_CYC = `UFS_REG_STAB_US * `UFS_CLK_MHZ,
  parameter int PLL_STAB_CYC = `UFS_PLL_STAB_US * `UFS_CLK_MHZ,
  parameter int SUSP_CYC = `UFS_SUSP_IDLE_US * `UFS_CLK_MHZ
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // bus power sense pin
  input wire logic vbus_i,
  // USB data lines
  input wire logic plus_data_line_i,
  input wire logic minus_data_line_i,
  output logic plus_data_line_o,
  output logic plus_data_line_oe_o,
  output logic minus_data_line_o,
  output logic minus_data_line_oe_o,
  output logic dp_pullup_o,
  // power and clock controls
  output logic low_regulator_enable_o,
  output logic high_regulator_enable_o,
  output logic pll_run_enable_o,
  output logic pll_clock_ready_o,
  output logic controller_reset_release_o,
  output logic bus_access_wait_select_o,
  output logic bus_suspended_o
);
  localparam int RST_CYC = `UFS_RST_CYC;

  ufs_req_t req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // pin synchronisers: stage one feeds stage two only
  logic [2:0] pin_s1, pin_s2;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else if (ce_i) begin
      pin_s1 <= {vbus_i, plus_data_line_i, minus_data_line_i};
      pin_s2 <= pin_s1;
    end
  end
  logic vbus_ok;
  ufs_line_t line;
  assign vbus_ok = pin_s2[2];
  // full-speed device: J is D+ high, K is D- high
  assign line = ufs_line_t'(pin_s2[1:0] == 2'h2 ? UFS_J :
                            pin_s2[1:0] == 2'h1 ? UFS_K :
                            pin_s2[1:0] == 2'h0 ? UFS_SE0 : UFS_SE1);

  // control state
  logic unlocked, next_unlocked;
  ufs_misc_t misc, next_misc;
  ufs_epcfg_t [2:0] epcfg, next_epcfg;
  logic [1:0] fsel_ep, next_fsel_ep;
  logic [5:0] fptr, next_fptr;
  logic [31:0] rdata, next_rdata;
  logic brst_flag, next_brst_flag;
  logic rsm_flag, next_rsm_flag;
  logic fifo_we;
  logic [7:0] fifo_addr;
  logic [7:0] fifo [0:`UFS_FIFO_BYTES-1];
  logic reg_ok, pll_ok;
  logic ev_brst, ev_rsm;
  ufs_sie_t serial_interface_engine;

  // usb registers open only once detect bit set and power present
  logic usb_open, fifo_open;
  assign usb_open = misc.vdet & vbus_ok;
  assign fifo_open = usb_open;
  // region base is fixed per endpoint, pointer wraps within 64 bytes
  assign fifo_addr = {fsel_ep, fptr};

  // register writes, reads and sticky event flags
  always_comb begin
    next_unlocked = unlocked;
    next_misc = misc;
    next_epcfg = epcfg;
    next_fsel_ep = fsel_ep;
    next_fptr = fptr;
    next_rdata = 32'h0;
    fifo_we = 1'b0;
    next_brst_flag = brst_flag;
    next_rsm_flag = rsm_flag;
    if (req.wr) begin
      case (req.addr)
        `UFS_OFS_GUARD: next_unlocked = (req.wdata[15:0] == `UFS_GUARD_KEY);
        `UFS_OFS_MISC: begin
          if (unlocked) begin
            next_misc.pll = req.wdata[`UFS_MISC_PLL];
            next_misc.rst_rel = req.wdata[`UFS_MISC_RST];
            next_misc.vdet = req.wdata[`UFS_MISC_VDET];
            next_misc.wait_sel = req.wdata[`UFS_MISC_WAIT];
            if (vbus_ok) begin
              next_misc.lreg = req.wdata[`UFS_MISC_LREG];
              next_misc.hreg = req.wdata[`UFS_MISC_HREG];
            end
          end
          next_misc.pull_en = req.wdata[`UFS_MISC_PULL];
        end
        `UFS_OFS_STAT: begin
          // write one clears; a new event below still wins
          if (req.wdata[`UFS_ST_BRST]) next_brst_flag = 1'b0;
          if (req.wdata[`UFS_ST_RSM]) next_rsm_flag = 1'b0;
        end
        `UFS_OFS_EPCFG: begin
          if (usb_open) begin
            for (int i = 0; i < 3; i++) begin
              // isochronous endpoints are not supported
              if (req.wdata[8*i+6 -: 2] != `UFS_TT_ISO) begin
                next_epcfg[i] = ufs_epcfg_t'(req.wdata[8*i +: 8]);
              end
            end
          end
        end
        `UFS_OFS_FSEL: begin
          if (usb_open) begin
            next_fsel_ep = req.wdata[7:6];
            next_fptr = req.wdata[5:0];
          end
        end
        `UFS_OFS_FDATA: begin
          if (fifo_open) begin
            fifo_we = 1'b1;
            next_fptr = fptr + 6'h01;
          end
        end
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        `UFS_OFS_GUARD: next_rdata = {31'h0, unlocked};
        `UFS_OFS_MISC: next_rdata = {25'h0, misc};
        `UFS_OFS_STAT: next_rdata = {25'h0, usb_open, rsm_flag, brst_flag,
                                     bus_suspended_o, vbus_ok, pll_ok, reg_ok};
        `UFS_OFS_EPCFG: next_rdata = usb_open ? {8'h0, epcfg} : 32'h0;
        `UFS_OFS_FSEL: next_rdata = usb_open ? {24'h0, fsel_ep, fptr} : 32'h0;
        `UFS_OFS_FDATA: begin
          if (fifo_open) begin
            next_rdata = {24'h0, fifo[fifo_addr]};
            next_fptr = fptr + 6'h01;
          end
        end
        default: next_rdata = 32'h0;
      endcase
    end
    if (ev_brst) next_brst_flag = 1'b1;
    if (ev_rsm) next_rsm_flag = 1'b1;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      unlocked <= 1'b0;
      misc <= ufs_misc_t'(`UFS_MISC_RESET);
      epcfg <= {3{ufs_epcfg_t'(`UFS_EPCFG_RESET)}};
      fsel_ep <= 2'h0;
      fptr <= 6'h00;
      rdata <= 32'h0;
      brst_flag <= 1'b0;
      rsm_flag <= 1'b0;
    end else if (ce_i) begin
      unlocked <= next_unlocked;
      misc <= next_misc;
      epcfg <= next_epcfg;
      fsel_ep <= next_fsel_ep;
      fptr <= next_fptr;
      rdata <= next_rdata;
      brst_flag <= next_brst_flag;
      rsm_flag <= next_rsm_flag;
    end
  end

  // fifo storage has no reset; contents undefined until written
  always_ff @(posedge mclk_i) begin
    if (ce_i && fifo_we) begin
      fifo[fifo_addr] <= req.wdata[7:0];
    end
  end

  // stabilization timers: readiness only after the full count
  logic [19:0] reg_cnt, next_reg_cnt, pll_cnt, next_pll_cnt;
  logic next_reg_ok, next_pll_ok;
  always_comb begin
    next_reg_cnt = reg_cnt;
    next_reg_ok = reg_ok;
    if (!(misc.lreg & misc.hreg)) begin
      next_reg_cnt = 20'h0;
      next_reg_ok = 1'b0;
    end else if (reg_cnt == 20'(REG_STAB_CYC - 1)) begin
      next_reg_ok = 1'b1;
    end else begin
      next_reg_cnt = reg_cnt + 20'h1;
    end
    next_pll_cnt = pll_cnt;
    next_pll_ok = pll_ok;
    if (!misc.pll) begin
      next_pll_cnt = 20'h0;
      next_pll_ok = 1'b0;
    end else if (pll_cnt == 20'(PLL_STAB_CYC - 1)) begin
      next_pll_ok = 1'b1;
    end else begin
      next_pll_cnt = pll_cnt + 20'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_cnt <= 20'h0;
      pll_cnt <= 20'h0;
      reg_ok <= 1'b0;
      pll_ok <= 1'b0;
    end else if (ce_i) begin
      reg_cnt <= next_reg_cnt;
      pll_cnt <= next_pll_cnt;
      reg_ok <= next_reg_ok;
      pll_ok <= next_pll_ok;
    end
  end

  // serial engine bus events; runs only while released and connected
  ufs_sie_t next_sie;
  logic [16:0] idle_cnt, next_idle_cnt;
  logic [6:0] se0_cnt, next_se0_cnt;
  logic sie_run;
  assign sie_run = misc.rst_rel & usb_open & pll_ok;
  always_comb begin
    next_sie = serial_interface_engine;
    next_idle_cnt = idle_cnt;
    next_se0_cnt = se0_cnt;
    ev_brst = 1'b0;
    ev_rsm = 1'b0;
    next_se0_cnt = (line == UFS_SE0) ? se0_cnt + 7'h1 : 7'h0;
    // saturate only while the line holds, so a later event counts afresh
    if (line == UFS_SE0 && se0_cnt == 7'(RST_CYC)) next_se0_cnt = se0_cnt;
    next_idle_cnt = (line == UFS_J) ? idle_cnt + 17'h1 : 17'h0;
    if (line == UFS_J && idle_cnt == 17'(SUSP_CYC)) next_idle_cnt = idle_cnt;
    if (!sie_run) begin
      next_sie = UFS_S_RUN;
      next_se0_cnt = 7'h0;
      next_idle_cnt = 17'h0;
    end else begin
      case (serial_interface_engine)
        UFS_S_RUN: begin
          if (se0_cnt == 7'(RST_CYC - 1)) begin
            next_sie = UFS_S_RESET;
            ev_brst = 1'b1;
          end else if (idle_cnt == 17'(SUSP_CYC - 1)) begin
            next_sie = UFS_S_SUSP;
          end
        end
        UFS_S_SUSP: begin
          if (line == UFS_K) begin
            next_sie = UFS_S_RUN;
            ev_rsm = 1'b1;
          end else if (se0_cnt == 7'(RST_CYC - 1)) begin
            next_sie = UFS_S_RESET;
            ev_brst = 1'b1;
          end
        end
        UFS_S_RESET: begin
          if (line != UFS_SE0) next_sie = UFS_S_RUN;
        end
        default: next_sie = UFS_S_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_interface_engine <= UFS_S_RUN;
      idle_cnt <= 17'h0;
      se0_cnt <= 7'h0;
    end else if (ce_i) begin
      serial_interface_engine <= next_sie;
      idle_cnt <= next_idle_cnt;
      se0_cnt <= next_se0_cnt;
    end
  end

  // registered outputs; data lines only listened to here
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 32'h0;
      plus_data_line_o <= 1'b0;
      plus_data_line_oe_o <= 1'b0;
      minus_data_line_o <= 1'b0;
      minus_data_line_oe_o <= 1'b0;
      dp_pullup_o <= 1'b0;
      low_regulator_enable_o <= 1'b0;
      high_regulator_enable_o <= 1'b0;
      pll_run_enable_o <= 1'b0;
      pll_clock_ready_o <= 1'b0;
      controller_reset_release_o <= 1'b0;
      bus_access_wait_select_o <= 1'b0;
      bus_suspended_o <= 1'b0;
    end else if (ce_i) begin
      rdata_o <= next_rdata;
      plus_data_line_o <= 1'b0;
      plus_data_line_oe_o <= 1'b0;
      minus_data_line_o <= 1'b0;
      minus_data_line_oe_o <= 1'b0;
      // pull-up only with power present, so the host sees a full-speed device
      dp_pullup_o <= next_misc.pull_en & vbus_ok;
      low_regulator_enable_o <= next_misc.lreg;
      high_regulator_enable_o <= next_misc.hreg;
      pll_run_enable_o <= next_misc.pll;
      pll_clock_ready_o <= next_pll_ok;
      controller_reset_release_o <= next_misc.rst_rel;
      bus_access_wait_select_o <= next_misc.wait_sel;
      bus_suspended_o <= (next_sie == UFS_S_SUSP);
    end
  end
endmodule

// ===== dv/ufs_ctrl_assertions.sv
`timescale 1ns/1ps
`include "ufs_defs.svh"
module ufs_ctrl_chk #(
  parameter int PLL_STAB_CYC = 20
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // pins and controls
  input wire logic vbus_i,
  input wire logic plus_data_line_oe_o,
  input wire logic minus_data_line_oe_o,
  input wire logic dp_pullup_o,
  input wire logic low_regulator_enable_o,
  input wire logic high_regulator_enable_o,
  input wire logic pll_run_enable_o,
  input wire logic pll_clock_ready_o,
  input wire logic controller_reset_release_o,
  input wire logic bus_access_wait_select_o,
  input wire logic bus_suspended_o
);
  logic unl, next_unl, mwr;
  logic [15:0] pcnt, next_pcnt;
  assign mwr = ce_i && wr_i && (addr_i == `UFS_OFS_MISC);
  // shadow guard state and count of cycles with the pll bit up
  always_comb begin
    next_unl = unl;
    if (ce_i && wr_i && addr_i == `UFS_OFS_GUARD) begin
      next_unl = (wdata_i[15:0] == `UFS_GUARD_KEY);
    end
    next_pcnt = pll_run_enable_o ? ((&pcnt) ? pcnt : pcnt + 16'h0001) : 16'h0000;
    if (!ce_i) next_pcnt = pcnt; // frozen cycles are not counted
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      unl <= 1'b0;
      pcnt <= 16'h0000;
    end else begin
      unl <= next_unl;
      pcnt <= next_pcnt;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_rd_idle; $past(ce_i) && !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  property p_freeze;
    !ce_i |=> $stable(low_regulator_enable_o) && $stable(pll_run_enable_o)
      && $stable(controller_reset_release_o) && $stable(rdata_o);
  endproperty
  property p_no_drive; !plus_data_line_oe_o && !minus_data_line_oe_o; endproperty
  property p_pull_vbus; !vbus_i [*5] |-> !dp_pullup_o; endproperty
  property p_locked;
    mwr && !unl |=> $stable(pll_run_enable_o) && $stable(controller_reset_release_o)
      && $stable(bus_access_wait_select_o) && $stable(low_regulator_enable_o);
  endproperty
  property p_pll_wr; mwr && unl |=> pll_run_enable_o == $past(wdata_i[0]); endproperty
  property p_rst_wr;
    mwr && unl |=> controller_reset_release_o == $past(wdata_i[3])
      && bus_access_wait_select_o == $past(wdata_i[5]);
  endproperty
  property p_reg_novbus;
    !vbus_i [*4] ##1 mwr |=> !$rose(low_regulator_enable_o) && !$rose(high_regulator_enable_o);
  endproperty
  property p_pll_early;
    pll_clock_ready_o && pll_run_enable_o |-> pcnt >= PLL_STAB_CYC - 2;
  endproperty
  property p_pll_late; pcnt == PLL_STAB_CYC + 3 |-> pll_clock_ready_o; endproperty
  property p_susp;
    $rose(bus_suspended_o) |-> controller_reset_release_o && pll_clock_ready_o;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_no_drive: assert property (p_no_drive) else $error("data line driven");
  a_pull_vbus: assert property (p_pull_vbus) else $error("pull-up without bus power");
  a_locked: assert property (p_locked) else $error("locked misc write took effect");
  a_pll_wr: assert property (p_pll_wr) else $error("pll enable not written");
  a_rst_wr: assert property (p_rst_wr) else $error("reset or wait not written");
  a_reg_novbus: assert property (p_reg_novbus) else $error("regulator on, no vbus");
  a_pll_early: assert property (p_pll_early) else $error("pll ready too early");
  a_pll_late: assert property (p_pll_late) else $error("pll ready too late");
  a_susp: assert property (p_susp) else $error("suspend while engine idle");
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  c_unl_wr: cover property (mwr && unl);
  c_ready: cover property ($rose(pll_clock_ready_o));
  c_susp: cover property ($rose(bus_suspended_o));
endmodule
bind ufs_ctrl ufs_ctrl_chk #(.PLL_STAB_CYC(PLL_STAB_CYC)) ufs_ctrl_chk_inst (.*);

// ===== dv/ufs_host_model.sv
`timescale 1ns/1ps
module ufs_host_model import ufs_pkg::*; (
  // host side control
  input wire logic drive_i,
  input wire ufs_line_t state_i,
  // device pull-up and resulting line levels
  input wire logic pullup_i,
  output logic dp_o,
  output logic dm_o
);
  // full-speed coding: J has D+ high; a released bus sits on its resistors
  always_comb begin
    if (drive_i) begin
      dp_o = (state_i == UFS_J) || (state_i == UFS_SE1);
      dm_o = (state_i == UFS_K) || (state_i == UFS_SE1);
    end else begin
      dp_o = pullup_i;
      dm_o = 1'b0;
    end
  end
endmodule

// ===== dv/ufs_ctrl_tb.sv
`timescale 1ns/1ps
`include "ufs_defs.svh"
module ufs_ctrl_tb import ufs_pkg::*; ;
  localparam int RCYC = 20;
  localparam int PCYC = 20;
  localparam int SCYC = 100;
  logic mclk_i, reset_n_i, vbus_i, wr_i, rd_i, host_drv, dp_h, dm_h, dp_o, dp_oe, dm_o, dm_oe;
  logic pull, lreg, hreg, pll, rdy, rst_rel, wsel, susp, ce;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, seed, rv, cfg, nw;
  ufs_line_t host_st;
  int bad_count, checks;
  ufs_ctrl #(.REG_STAB_CYC(RCYC), .PLL_STAB_CYC(PCYC), .SUSP_CYC(SCYC)) ufs_ctrl_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .vbus_i(vbus_i),
    .plus_data_line_i(dp_oe ? dp_o : dp_h), .minus_data_line_i(dm_oe ? dm_o : dm_h),
    .plus_data_line_o(dp_o), .plus_data_line_oe_o(dp_oe), .minus_data_line_o(dm_o),
    .minus_data_line_oe_o(dm_oe), .dp_pullup_o(pull), .low_regulator_enable_o(lreg),
    .high_regulator_enable_o(hreg), .pll_run_enable_o(pll), .pll_clock_ready_o(rdy),
    .controller_reset_release_o(rst_rel), .bus_access_wait_select_o(wsel),
    .bus_suspended_o(susp));
  ufs_host_model ufs_host_model_inst (.drive_i(host_drv), .state_i(host_st),
    .pullup_i(pull), .dp_o(dp_h), .dm_o(dm_h));
  // one 25 MHz register clock; the processor clock limit is kept by the system
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(rdata_o & m, e);
  endtask
  // an isochronous code is moved to control so the byte is accepted
  function automatic logic [7:0] okcfg(input logic [7:0] r);
    okcfg = (r[6:5] == 2'b01) ? (r ^ 8'h20) : r;
  endfunction
  function automatic logic [7:0] pat(input int e);
    pat = rv[8 * e +: 8];
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    repeat (6000) @(posedge mclk_i);
    bad_count++;
    complete_run();
  end
  initial begin
    seed = 32'hac47dadd;
    {reset_n_i, vbus_i, wr_i, rd_i, host_drv, addr_i, wdata_i} = '0;
    host_st = UFS_J;
    ce = 1'b1;
    bad_count = 0;
    checks = 0;
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    // locked guard: only the pull-up bit is taken, and no pull-up without vbus
    wr(`UFS_OFS_MISC, 32'h0000007F);
    rd(`UFS_OFS_MISC, 32'h7F, 32'h40);
    chk(pull, 1'b0);
    wr(`UFS_OFS_GUARD, {16'h0000, `UFS_GUARD_KEY});
    rd(`UFS_OFS_GUARD, 32'h1, 32'h1);
    wr(`UFS_OFS_MISC, 32'h00000026);
    rd(`UFS_OFS_MISC, 32'h7F, 32'h20);
    rd(`UFS_OFS_EPCFG, 32'hFFFFFFFF, 32'h0);
    // attach: regulators, then pll, each with its settling time
    vbus_i <= 1'b1;
    host_drv <= 1'b1;
    cyc(4);
    wr(`UFS_OFS_MISC, 32'h00000066);
    cyc(2);
    chk({lreg, hreg, wsel, pull}, 4'hF);
    rd(`UFS_OFS_STAT, 32'h1, 32'h0);
    cyc(RCYC);
    rd(`UFS_OFS_STAT, 32'h5, 32'h5);
    wr(`UFS_OFS_MISC, 32'h00000067);
    cyc(PCYC - 4);
    chk({pll, rdy}, 2'b10);
    cyc(8);
    rd(`UFS_OFS_STAT, 32'h2, 32'h2);
    // frozen clock enable: a write is not taken and all outputs hold
    ce <= 1'b0;
    wr(`UFS_OFS_MISC, 32'h00000040);
    cyc(2);
    chk({lreg, hreg, pll, wsel}, 4'hF);
    ce <= 1'b1;
    // release reset and open the registers while the host holds bus reset
    host_st <= UFS_SE0;
    wr(`UFS_OFS_MISC, 32'h0000007F);
    cyc(1);
    chk(rst_rel, 1'b1);
    rd(`UFS_OFS_STAT, 32'h40, 32'h40);
    cyc(70);
    host_st <= UFS_J;
    rd(`UFS_OFS_STAT, 32'h10, 32'h10);
    wr(`UFS_OFS_STAT, 32'h00000010);
    rd(`UFS_OFS_STAT, 32'h10, 32'h0);
    chk(susp, 1'b0);
    cyc(SCYC + 10);
    chk(susp, 1'b1);
    host_st <= UFS_K;
    cyc(10);
    rd(`UFS_OFS_STAT, 32'h20, 32'h20);
    host_st <= UFS_J;
    // endpoint setup; an isochronous byte is refused, its neighbours are not
    rv = $random(seed);
    cfg = {8'h00, okcfg(rv[23:16]), okcfg(rv[15:8]), okcfg(rv[7:0])};
    wr(`UFS_OFS_EPCFG, cfg);
    rd(`UFS_OFS_EPCFG, 32'hFFFFFF, cfg);
    nw = cfg ^ 32'h1;
    nw[14:13] = 2'b01;
    wr(`UFS_OFS_EPCFG, nw);
    nw[15:8] = cfg[15:8];
    rd(`UFS_OFS_EPCFG, 32'hFFFFFF, nw);
    // a write at pointer 63 wraps to 0 of the same 64-byte region
    rv = $random(seed);
    for (int e = 0; e < 4; e++) begin
      wr(`UFS_OFS_FSEL, {24'h0, e[1:0], 6'h3F});
      wr(`UFS_OFS_FDATA, {24'h0, pat(e)});
      wr(`UFS_OFS_FDATA, {24'h0, ~pat(e)});
    end
    for (int e = 0; e < 4; e++) begin
      wr(`UFS_OFS_FSEL, {24'h0, e[1:0], 6'h3F});
      rd(`UFS_OFS_FDATA, 32'hFF, {24'h0, pat(e)});
      wr(`UFS_OFS_FSEL, {24'h0, e[1:0], 6'h00});
      rd(`UFS_OFS_FDATA, 32'hFF, {24'h0, ~pat(e)});
    end
    // relock with a random key; a locked write moves only the pull-up bit
    rv = $random(seed);
    if (rv[15:0] == `UFS_GUARD_KEY) rv = ~rv;
    wr(`UFS_OFS_GUARD, rv);
    rd(`UFS_OFS_GUARD, 32'h1, 32'h0);
    wr(`UFS_OFS_MISC, 32'h0);
    rd(`UFS_OFS_MISC, 32'h7F, 32'h3F);
    wr(8'h40, rv);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    // detach: power down, registers close, pull-up drops with vbus
    wr(`UFS_OFS_GUARD, {16'h0000, `UFS_GUARD_KEY});
    wr(`UFS_OFS_MISC, 32'h00000040);
    cyc(2);
    chk({lreg, hreg, pll, rst_rel}, 4'h0);
    rd(`UFS_OFS_EPCFG, 32'hFFFFFF, 32'h0);
    vbus_i <= 1'b0;
    cyc(6);
    chk(pull, 1'b0);
    complete_run();
  end
endmodule
